//--- rtl/indirect_access_defines.vh
// register offsets, field positions, codes and reset values of the bridge
`ifndef INDIRECT_ACCESS_DEFINES_VH
`define INDIRECT_ACCESS_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define AW_CTL_ADDR     8'h40
`define AW_OFS_ADDR     8'h41
`define AW_VAL_ADDR     8'h42
`define BR_CTL_ADDR     8'h48
`define BR_ADL_ADDR     8'h49
`define BR_ADH_ADDR     8'h4A
`define BR_B0_ADDR      8'h4B
`define BR_B1_ADDR      8'h4C
`define BR_B2_ADDR      8'h4D
`define BR_B3_ADDR      8'h4E

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define REG_RESET       8'h00
`define WORD_RESET      32'h00000000
`define CTL_MASK        8'h1F

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define AW_DIR_BIT      0
`define AW_INC_BIT      1
`define AW_SEL_LO       2
`define AW_SEL_HI       4
`define BR_EN_BIT       0
`define BR_RD_BIT       1
`define BR_INC_BIT      2
`define BR_SEL_LO       3
`define BR_SEL_HI       4

// ----------------------------------------------------------------
// target codes and address steps
// ----------------------------------------------------------------
`define AW_SEL_OFF      3'h0
`define AW_SEL_RX       3'h4
`define AW_SEL_TX       3'h5
`define BR_TGT_RX       2'h0
`define BR_TGT_SRAM     2'h1
`define BR_TGT_CFG      2'h2
`define BR_TGT_DIE      2'h3
`define AW_STEP         8'h01
`define BR_STEP_RX      16'h0004
`define BR_STEP_OTHER   16'h0001

`endif

//--- rtl/analog_window_port.v
// handshake master toward the analog register blocks
`timescale 1ns/1ns
`include "indirect_access_defines.vh"

module analog_window_port (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       start_i,
  input  wire       write_i,
  input  wire [2:0] sel_i,
  input  wire [7:0] offset_i,
  input  wire [7:0] wdata_i,
  output reg        done_o,
  output reg  [7:0] rdata_o,
  output reg        ana_req_o,
  output reg        ana_write_o,
  output reg        ana_target_o,
  output reg  [7:0] ana_addr_o,
  output reg  [7:0] ana_wdata_o,
  input  wire [7:0] ana_rdata_i,
  input  wire       ana_ack_i
);

  wire sel_ok;

  assign sel_ok = (sel_i == `AW_SEL_RX) || (sel_i == `AW_SEL_TX);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o       <= 1'b0;
      rdata_o      <= `REG_RESET;
      ana_req_o    <= 1'b0;
      ana_write_o  <= 1'b0;
      ana_target_o <= 1'b0;
      ana_addr_o   <= `REG_RESET;
      ana_wdata_o  <= `REG_RESET;
    end else begin
      done_o <= 1'b0;
      if (start_i && sel_ok) begin
        ana_req_o    <= 1'b1;
        ana_write_o  <= write_i;
        ana_target_o <= (sel_i == `AW_SEL_TX);
        ana_addr_o   <= offset_i;
        ana_wdata_o  <= wdata_i;
      end else if (start_i) begin
        // off or reserved target: finish at once, nothing leaves
        done_o  <= 1'b1;
        rdata_o <= `REG_RESET;
      end else if (ana_req_o && ana_ack_i) begin
        ana_req_o <= 1'b0;
        done_o    <= 1'b1;
        if (!ana_write_o) begin
          rdata_o <= ana_rdata_i;
        end
      end
    end
  end

endmodule // analog_window_port

//--- rtl/peripheral_bus_port.v
// single-transfer peripheral bus master, setup then access phase
`timescale 1ns/1ns
`include "indirect_access_defines.vh"

module peripheral_bus_port (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        start_i,
  input  wire        write_i,
  input  wire        discard_i,
  input  wire [15:0] addr_i,
  input  wire [31:0] wdata_i,
  output reg         done_o,
  output reg  [31:0] rdata_o,
  output reg         psel_o,
  output reg         penable_o,
  output reg         pwrite_o,
  output reg  [15:0] paddr_o,
  output reg  [31:0] pwdata_o,
  input  wire [31:0] prdata_i,
  input  wire        pready_i
);

  localparam ST_IDLE   = 2'b00;
  localparam ST_SETUP  = 2'b01;
  localparam ST_ACCESS = 2'b10;

  reg [1:0] state_q;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q   <= ST_IDLE;
      done_o    <= 1'b0;
      rdata_o   <= `WORD_RESET;
      psel_o    <= 1'b0;
      penable_o <= 1'b0;
      pwrite_o  <= 1'b0;
      paddr_o   <= 16'h0000;
      pwdata_o  <= `WORD_RESET;
    end else begin
      done_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start_i && discard_i) begin
            done_o <= 1'b1;
          end else if (start_i) begin
            psel_o   <= 1'b1;
            pwrite_o <= write_i;
            paddr_o  <= addr_i;
            pwdata_o <= wdata_i;
            state_q  <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          penable_o <= 1'b1;
          state_q   <= ST_ACCESS;
        end
        ST_ACCESS: begin
          if (pready_i) begin
            psel_o    <= 1'b0;
            penable_o <= 1'b0;
            done_o    <= 1'b1;
            if (!pwrite_o) begin
              rdata_o <= prdata_i;
            end
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // peripheral_bus_port

//--- rtl/indirect_register_access.v
// windowed indirect access to analog registers and the peripheral bus
`timescale 1ns/1ns
`include "indirect_access_defines.vh"

// Behaviour
// - select field picks analog target or off
// - analog offset steps by one after access
// - direction bit: zero writes, one reads
// - offset register addresses analog target register
// - value write launches indirect analog write
// - value read returns selected analog register
// - bridge target field picks bus space
// - bridge address steps four or one
// - read-start bit fetches word into bytes
// - read-start bit self-clears after read completes
// - bridge works only while enabled
// - address bytes at 0x49 and 0x4A
// - word bytes 0,1 at 0x4B, 0x4C
// - all window registers reset to zero
// - word bytes 2,3 at 0x4D, 0x4E
module indirect_register_access (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_rdata_o,
  output reg         reg_ack_o,
  output wire        ana_req_o,
  output wire        ana_write_o,
  output wire        ana_target_o,
  output wire [7:0]  ana_addr_o,
  output wire [7:0]  ana_wdata_o,
  input  wire [7:0]  ana_rdata_i,
  input  wire        ana_ack_i,
  output wire        psel_o,
  output wire        penable_o,
  output wire        pwrite_o,
  output wire [15:0] paddr_o,
  output wire [31:0] pwdata_o,
  input  wire [31:0] prdata_i,
  input  wire        pready_i,
  output wire [1:0]  bus_target_o
);

  // ----------------------------------------------------------------
  // host port sequencing
  // ----------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_ANA  = 1'b1;

  reg         state_q;
  reg         state_d;
  reg  [7:0]  actl_q;
  reg  [7:0]  aofs_q;
  reg  [7:0]  aval_q;
  reg         ard_q;
  reg  [7:0]  bctl_q;
  reg  [15:0] badr_q;
  reg  [31:0] bword_q;
  reg         bbusy_q;
  reg  [7:0]  rdata_d;

  wire        host_wr;
  wire        host_rd;
  wire        hit_actl;
  wire        hit_aofs;
  wire        hit_aval;
  wire        hit_bctl;
  wire        hit_badl;
  wire        hit_badh;
  wire        hit_b0;
  wire        hit_b1;
  wire        hit_b2;
  wire        hit_b3;
  wire        hit_bridge;
  wire        bwr_ok;
  wire        ana_dir;
  wire        ana_start;
  wire        ana_done;
  wire [7:0]  ana_rdata;
  wire        br_rd_start;
  wire        br_wr_start;
  wire        br_start;
  wire        br_discard;
  wire        br_done;
  wire [31:0] br_rdata;
  wire [15:0] br_step;

  // requests are taken only while no analog access is outstanding
  assign host_wr = reg_wr_i && (state_q == ST_IDLE);
  assign host_rd = reg_rd_i && (state_q == ST_IDLE);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign hit_actl = (reg_addr_i == `AW_CTL_ADDR);
  assign hit_aofs = (reg_addr_i == `AW_OFS_ADDR);
  assign hit_aval = (reg_addr_i == `AW_VAL_ADDR);
  assign hit_bctl = (reg_addr_i == `BR_CTL_ADDR);
  assign hit_badl = (reg_addr_i == `BR_ADL_ADDR);
  assign hit_badh = (reg_addr_i == `BR_ADH_ADDR);
  assign hit_b0   = (reg_addr_i == `BR_B0_ADDR);
  assign hit_b1   = (reg_addr_i == `BR_B1_ADDR);
  assign hit_b2   = (reg_addr_i == `BR_B2_ADDR);
  assign hit_b3   = (reg_addr_i == `BR_B3_ADDR);

  assign hit_bridge = hit_bctl | hit_badl | hit_badh |
                      hit_b0 | hit_b1 | hit_b2 | hit_b3;

  // bridge registers are frozen while a bus transfer is in flight,
  // so the address and data under the transfer cannot shift
  assign bwr_ok = host_wr && !bbusy_q;

  // ----------------------------------------------------------------
  // analog window launch
  // ----------------------------------------------------------------
  assign ana_dir = actl_q[`AW_DIR_BIT];

  // a value write launches only in write direction, a value read only
  // in read direction; otherwise the value register acts as storage
  assign ana_start = (host_wr && hit_aval && !ana_dir) ||
                     (host_rd && hit_aval && ana_dir);

  analog_window_port u_analog_window_port (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .start_i      (ana_start),
    .write_i      (host_wr),
    .sel_i        (actl_q[`AW_SEL_HI:`AW_SEL_LO]),
    .offset_i     (aofs_q),
    .wdata_i      (reg_wdata_i),
    .done_o       (ana_done),
    .rdata_o      (ana_rdata),
    .ana_req_o    (ana_req_o),
    .ana_write_o  (ana_write_o),
    .ana_target_o (ana_target_o),
    .ana_addr_o   (ana_addr_o),
    .ana_wdata_o  (ana_wdata_o),
    .ana_rdata_i  (ana_rdata_i),
    .ana_ack_i    (ana_ack_i)
  );

  // ----------------------------------------------------------------
  // bridge launch
  // ----------------------------------------------------------------
  // the read uses whatever address bytes are loaded at that moment
  assign br_rd_start = bwr_ok && hit_bctl &&
                       reg_wdata_i[`BR_EN_BIT] &&
                       reg_wdata_i[`BR_RD_BIT];

  // storing the top byte sends the whole word out; for a read-only target it is dropped
  assign br_wr_start = bwr_ok && hit_b3 && bctl_q[`BR_EN_BIT];

  assign br_start = br_rd_start || br_wr_start;

  assign br_discard = br_wr_start &&
    ((bctl_q[`BR_SEL_HI:`BR_SEL_LO] == `BR_TGT_CFG) ||
     (bctl_q[`BR_SEL_HI:`BR_SEL_LO] == `BR_TGT_DIE));

  assign br_step = (bctl_q[`BR_SEL_HI:`BR_SEL_LO] == `BR_TGT_RX) ?
                   `BR_STEP_RX : `BR_STEP_OTHER;

  assign bus_target_o = bctl_q[`BR_SEL_HI:`BR_SEL_LO];

  peripheral_bus_port u_peripheral_bus_port (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .start_i   (br_start),
    .write_i   (br_wr_start),
    .discard_i (br_discard),
    .addr_i    (badr_q),
    .wdata_i   ({reg_wdata_i, bword_q[23:0]}),
    .done_o    (br_done),
    .rdata_o   (br_rdata),
    .psel_o    (psel_o),
    .penable_o (penable_o),
    .pwrite_o  (pwrite_o),
    .paddr_o   (paddr_o),
    .pwdata_o  (pwdata_o),
    .prdata_i  (prdata_i),
    .pready_i  (pready_i)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always @* begin
    rdata_d = `REG_RESET;
    case (reg_addr_i)
      `AW_CTL_ADDR: rdata_d = actl_q;
      `AW_OFS_ADDR: rdata_d = aofs_q;
      `AW_VAL_ADDR: rdata_d = aval_q;
      `BR_CTL_ADDR: rdata_d = bctl_q;
      `BR_ADL_ADDR: rdata_d = badr_q[7:0];
      `BR_ADH_ADDR: rdata_d = badr_q[15:8];
      `BR_B0_ADDR:  rdata_d = bword_q[7:0];
      `BR_B1_ADDR:  rdata_d = bword_q[15:8];
      `BR_B2_ADDR:  rdata_d = bword_q[23:16];
      `BR_B3_ADDR:  rdata_d = bword_q[31:24];
      default:      rdata_d = `REG_RESET;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencing state
  // ----------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (ana_start) begin
          state_d = ST_ANA;
        end
      end
      ST_ANA: begin
        if (ana_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // host answer
  // ----------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q     <= ST_IDLE;
      ard_q       <= 1'b0;
      reg_ack_o   <= 1'b0;
      reg_rdata_o <= `REG_RESET;
    end else begin
      state_q   <= state_d;
      reg_ack_o <= 1'b0;
      if (ana_start) begin
        ard_q <= host_rd;
      end
      if (ana_done) begin
        reg_ack_o <= 1'b1;
        if (ard_q) begin
          reg_rdata_o <= ana_rdata;
        end
      end else if ((host_wr || host_rd) && !ana_start) begin
        reg_ack_o <= 1'b1;
        if (host_rd) begin
          reg_rdata_o <= rdata_d;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // analog window registers
  // ----------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      actl_q <= `REG_RESET;
      aofs_q <= `REG_RESET;
      aval_q <= `REG_RESET;
    end else begin
      if (host_wr && hit_actl) begin
        actl_q <= reg_wdata_i & `CTL_MASK;
      end
      if (host_wr && hit_aofs) begin
        aofs_q <= reg_wdata_i;
      end else if (ana_done && actl_q[`AW_INC_BIT]) begin
        aofs_q <= aofs_q + `AW_STEP;
      end
      if (host_wr && hit_aval) begin
        aval_q <= reg_wdata_i;
      end else if (ana_done && ard_q) begin
        aval_q <= ana_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // bridge registers
  // ----------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bctl_q  <= `REG_RESET;
      badr_q  <= {`REG_RESET, `REG_RESET};
      bword_q <= `WORD_RESET;
      bbusy_q <= 1'b0;
    end else begin
      if (br_start) begin
        bbusy_q <= 1'b1;
      end else if (br_done) begin
        bbusy_q <= 1'b0;
      end
      if (bwr_ok && hit_bctl) begin
        // start bit only sticks when a read really launches
        bctl_q <= reg_wdata_i & `CTL_MASK;
        bctl_q[`BR_RD_BIT] <= br_rd_start;
      end else if (br_done) begin
        bctl_q[`BR_RD_BIT] <= 1'b0;
      end
      if (bwr_ok && hit_badl) begin
        badr_q[7:0] <= reg_wdata_i;
      end else if (bwr_ok && hit_badh) begin
        badr_q[15:8] <= reg_wdata_i;
      end else if (br_done && bctl_q[`BR_INC_BIT]) begin
        badr_q <= badr_q + br_step;
      end
      // only a read that really ran refills the word; a dropped write to
      // a read-only target leaves pwrite_o stale, so it is not trusted
      if (br_done && bctl_q[`BR_RD_BIT] &&
          !bword_wr_hit(bwr_ok, hit_bridge)) begin
        bword_q <= br_rdata;
      end else if (bwr_ok && hit_b0) begin
        bword_q[7:0] <= reg_wdata_i;
      end else if (bwr_ok && hit_b1) begin
        bword_q[15:8] <= reg_wdata_i;
      end else if (bwr_ok && hit_b2) begin
        bword_q[23:16] <= reg_wdata_i;
      end else if (bwr_ok && hit_b3) begin
        bword_q[31:24] <= reg_wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // helper
  // ----------------------------------------------------------------
  // while busy bwr_ok is low, so a finishing read never races a store;
  // kept as a function so the guard reads plainly above
  function bword_wr_hit;
    input ok;
    input hit;
    begin
      bword_wr_hit = ok & hit;
    end
  endfunction

endmodule // indirect_register_access

//--- verif/indirect_register_access_properties.sv
// port checker for the indirect register bridge
`timescale 1ns/1ns
module irb_port_checker (
  input wire        clk_i,
  input wire        rst_i,
  input wire [7:0]  reg_addr_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [7:0]  reg_rdata_o,
  input wire        reg_ack_o,
  input wire        ana_req_o,
  input wire        ana_write_o,
  input wire [7:0]  ana_addr_o,
  input wire [7:0]  ana_rdata_i,
  input wire        ana_ack_i,
  input wire        psel_o,
  input wire        penable_o,
  input wire        pwrite_o,
  input wire [15:0] paddr_o,
  input wire        pready_i,
  input wire [1:0]  bus_target_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ana_hold;
    ana_req_o && !ana_ack_i |=> ana_req_o && $stable(ana_addr_o);
  endproperty
  a_ana_hold: assert property (p_ana_hold)
    else $error("analog request not held");
  property p_ana_done;
    ana_req_o && ana_ack_i |=> !ana_req_o ##1 reg_ack_o;
  endproperty
  a_ana_done: assert property (p_ana_done)
    else $error("analog access not closed");
  property p_ana_rdata;
    ana_req_o && ana_ack_i && !ana_write_o
      |=> ##1 reg_rdata_o == $past(ana_rdata_i, 2);
  endproperty
  a_ana_rdata: assert property (p_ana_rdata)
    else $error("analog read byte lost");
  property p_ana_launch;
    $rose(ana_req_o) |-> $past(reg_addr_i) == 8'h42
      && $past(reg_wr_i) == ana_write_o;
  endproperty
  a_ana_launch: assert property (p_ana_launch)
    else $error("analog access of wrong kind");
  property p_bus_setup;
    $rose(psel_o) |-> !penable_o ##1 penable_o;
  endproperty
  a_bus_setup: assert property (p_bus_setup)
    else $error("bus setup phase wrong");
  property p_bus_hold;
    psel_o && penable_o && !pready_i
      |=> psel_o && penable_o && $stable(paddr_o);
  endproperty
  a_bus_hold: assert property (p_bus_hold)
    else $error("bus access not held");
  property p_bus_end;
    psel_o && penable_o && pready_i |=> !psel_o && !penable_o;
  endproperty
  a_bus_end: assert property (p_bus_end)
    else $error("bus transfer not ended");
  property p_ro_write;
    psel_o && pwrite_o |-> !bus_target_o[1];
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("write cycle to read-only target");
  property p_reg_ack;
    (reg_wr_i || reg_rd_i) && reg_addr_i != 8'h42 && !ana_req_o
      |=> reg_ack_o;
  endproperty
  a_reg_ack: assert property (p_reg_ack)
    else $error("register access not answered");
endmodule // irb_port_checker

bind indirect_register_access irb_port_checker chk (.*);

//--- verif/far_side_model.sv
// far side: analog register blocks and peripheral bus targets
`timescale 1ns/1ns
module far_side_model (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        slow_i,
  input  wire        ana_req_o,
  input  wire        ana_write_o,
  input  wire        ana_target_o,
  input  wire [7:0]  ana_addr_o,
  input  wire [7:0]  ana_wdata_o,
  output reg  [7:0]  ana_rdata_i,
  output reg         ana_ack_i,
  input  wire        psel_o,
  input  wire        penable_o,
  input  wire        pwrite_o,
  input  wire [15:0] paddr_o,
  input  wire [31:0] pwdata_o,
  input  wire [1:0]  bus_target_o,
  output reg  [31:0] prdata_i,
  output reg         pready_i
);
  reg [7:0]  ana_mem [0:511];
  reg [31:0] bus_mem [0:1023];
  reg [1:0]  ana_wait_q;
  reg [1:0]  bus_wait_q;
  integer    i;
  wire [9:0] bus_idx = {bus_target_o, paddr_o[7:0]};
  wire [8:0] ana_idx = {ana_target_o, ana_addr_o};

  initial begin
    for (i = 0; i < 1024; i = i + 1) begin
      bus_mem[i] = 32'hC0DE0000 | i;
      ana_mem[i % 512] = 8'h00;
    end
  end

  // slow mode adds wait cycles so the bridge must hold its request;
  // idle data lines toggle so a stale sample never looks right
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ana_ack_i <= 1'b0;
      ana_wait_q <= 2'h0;
      ana_rdata_i <= 8'h5A;
    end else if (ana_ack_i || !ana_req_o) begin
      ana_ack_i <= 1'b0;
      ana_wait_q <= 2'h0;
      ana_rdata_i <= ~ana_rdata_i;
    end else if (ana_wait_q == (slow_i ? 2'h3 : 2'h0)) begin
      ana_ack_i <= 1'b1;
      ana_rdata_i <= ana_mem[ana_idx];
      if (ana_write_o) ana_mem[ana_idx] <= ana_wdata_o;
    end else ana_wait_q <= ana_wait_q + 2'h1;
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_i <= 1'b0;
      bus_wait_q <= 2'h0;
      prdata_i <= 32'h5A5A5A5A;
    end else if (pready_i || !(psel_o && penable_o)) begin
      pready_i <= 1'b0;
      bus_wait_q <= 2'h0;
      prdata_i <= ~prdata_i;
    end else if (bus_wait_q == (slow_i ? 2'h2 : 2'h0)) begin
      pready_i <= 1'b1;
      prdata_i <= bus_mem[bus_idx];
      if (pwrite_o) bus_mem[bus_idx] <= pwdata_o;
    end else bus_wait_q <= bus_wait_q + 2'h1;
  end
endmodule // far_side_model

//--- verif/test_indirect_register_access.sv
// self-checking bench for the indirect register bridge
`timescale 1ns/1ns
module test_indirect_register_access;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic slow_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  wire [7:0] reg_rdata_o, ana_addr_o, ana_wdata_o, ana_rdata_i;
  wire reg_ack_o, ana_req_o, ana_write_o, ana_target_o, ana_ack_i;
  wire psel_o, penable_o, pwrite_o, pready_i;
  wire [15:0] paddr_o;
  wire [31:0] pwdata_o, prdata_i;
  wire [1:0] bus_target_o;
  integer num_errors = 0;
  integer num_checks = 0;
  integer k;
  logic [7:0] rd_q;
  logic [7:0] regs [10] = '{8'h40, 8'h41, 8'h42, 8'h48, 8'h49,
                            8'h4A, 8'h4B, 8'h4C, 8'h4D, 8'h4E};

  indirect_register_access dut (.*);
  far_side_model partner (.*);

  always #25 clk_i = ~clk_i;

  task automatic fail(input string msg);
    num_errors = num_errors + 1;
    $display("mismatch at %0t: %s", $time, msg);
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
  endtask
  // one strobe, then wait for the answer
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
    integer n;
    n = 0;
    @(posedge clk_i) #1;
    reg_wr_i = w;
    reg_rd_i = !w;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(posedge clk_i) #1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    while (reg_ack_o !== 1'b1 && n < 40) begin
      @(posedge clk_i) #1;
      n = n + 1;
    end
    if (n == 40) fail("no register answer");
    rd_q = reg_rdata_o;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    access(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    access(1'b0, a, 8'h00);
    check(rd_q, e);
  endtask
  // poll the control register until no transfer is running
  task automatic bridge_wait;
    integer n;
    n = 0;
    rd_q = 8'h02;
    while ((rd_q[1] || psel_o) && n < 20) begin
      access(1'b0, 8'h48, 8'h00);
      n = n + 1;
    end
  endtask
  task automatic check_word(input logic [31:0] e);
    integer j;
    for (j = 0; j < 4; j = j + 1) rd(8'h4B + j[7:0], e[8*j +: 8]);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #(6000 * 50);
    fail("watchdog expired");
    conclude;
  end

  initial begin
    repeat (3) @(posedge clk_i);
    #1 rst_i = 1'b0;
    for (k = 0; k < 10; k++) rd(regs[k], 8'h00);
    wr(8'h43, 8'h77);
    rd(8'h43, 8'h00);
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h1F);
    // both analog targets, fast then slow answers
    for (k = 0; k < 2; k++) begin
      slow_i = k[0];
      wr(8'h40, {3'h0, 3'h4 + k[2:0], 2'b10});
      wr(8'h41, 8'h10);
      wr(8'h42, 8'h3C + k[7:0]);
      rd(8'h41, 8'h11);
      wr(8'h40, {3'h0, 3'h4 + k[2:0], 2'b01});
      wr(8'h41, 8'h10);
      rd(8'h42, 8'h3C + k[7:0]);
      rd(8'h41, 8'h10);
    end
    // off and reserved codes: reads give zero, writes go nowhere
    for (k = 0; k < 8; k++) if (k != 4 && k != 5) begin
      wr(8'h40, {3'h0, k[2:0], 2'b00});
      wr(8'h41, 8'h10);
      wr(8'h42, 8'hEE);
      wr(8'h40, {3'h0, k[2:0], 2'b11});
      wr(8'h41, 8'h10);
      rd(8'h42, 8'h00);
      rd(8'h41, 8'h11);
    end
    wr(8'h40, 8'h11);
    wr(8'h41, 8'h10);
    rd(8'h42, 8'h3C);
    // bridge reads from every target
    for (k = 0; k < 4; k++) begin
      slow_i = k[0];
      wr(8'h49, 8'h08);
      wr(8'h4A, 8'h01);
      wr(8'h48, {3'h0, k[1:0], 3'b111});
      check({6'h0, bus_target_o}, k[7:0]);
      bridge_wait;
      check(rd_q, {3'h0, k[1:0], 3'b101});
      check_word(32'hC0DE0000 | {k[1:0], 8'h08});
      rd(8'h49, k == 0 ? 8'h0C : 8'h09);
      rd(8'h4A, 8'h01);
    end
    // write a word to the SRAM target, then read it back
    wr(8'h48, 8'h0D);
    wr(8'h49, 8'h20);
    for (k = 0; k < 4; k++) wr(8'h4B + k[7:0], 8'h11 * (k[7:0] + 1));
    bridge_wait;
    rd(8'h49, 8'h21);
    wr(8'h49, 8'h20);
    wr(8'h48, 8'h0F);
    bridge_wait;
    check_word(32'h44332211);
    // write to the read-only configuration target is dropped
    wr(8'h48, 8'h15);
    wr(8'h49, 8'h08);
    for (k = 0; k < 4; k++) wr(8'h4B + k[7:0], 8'hF0);
    bridge_wait;
    rd(8'h49, 8'h09);
    check_word(32'hF0F0F0F0);
    wr(8'h49, 8'h08);
    wr(8'h48, 8'h17);
    bridge_wait;
    check_word(32'hC0DE0208);
    // disabled bridge never starts
    wr(8'h48, 8'h02);
    rd(8'h48, 8'h00);
    check({7'h0, psel_o}, 8'h00);
    conclude;
  end
endmodule // test_indirect_register_access
